// ### hw/ubr_pkg.sv
// Purpose: Shared constants for the serial receiver with baud generator.
// Assumes: Classic Wishbone slave, 32-bit data, one aligned word each.
// Notes:   Registers are 8 bits wide in the low byte of each word.
package ubr_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_BAUD_CTL  = 8'h00; // baud_control
   localparam logic [7:0] OFF_RX_STAT   = 8'h04; // receive_status_control
   localparam logic [7:0] OFF_DIV_LOW   = 8'h08; // baud_divisor_low
   localparam logic [7:0] OFF_DIV_HIGH  = 8'h0c; // baud_divisor_high
   localparam logic [7:0] OFF_TX_STAT   = 8'h10; // transmit_status_control
   localparam logic [7:0] OFF_RX_DATA   = 8'h14; // receive_data_register
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h18; // Sticky events, read only
   localparam logic [7:0] OFF_IRQ_CLR   = 8'h1c; // Write one to clear
   localparam logic [7:0] OFF_IRQ_EN    = 8'h20; // Event enables

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   // baud_control
   localparam int BC_IDLE      = 6;  // receive_idle_status, read only
   localparam int BC_WIDE      = 3;  // wide_divisor_select
   // receive_status_control
   localparam int RS_PORT_EN   = 7;  // port_enable
   localparam int RS_NINE      = 6;  // nine_bit_receive_select
   localparam int RS_CONT_EN   = 4;  // continuous_receive_enable
   localparam int RS_ADDR_DET  = 3;  // address_detect_enable
   localparam int RS_FRAME     = 2;  // framing_error_flag, read only
   localparam int RS_OVERRUN   = 1;  // overrun_error_flag, read only
   localparam int RS_NINTH     = 0;  // received_ninth_bit, read only
   // transmit_status_control
   localparam int TS_SYNC      = 4;  // Synchronous select
   localparam int TS_HIGH      = 2;  // high_speed_select
   localparam int TS_EMPTY     = 1;  // Transmit shift empty, read only
   // Interrupt status, clear and enable
   localparam int IRQ_RX       = 0;  // receive_flag / enable
   localparam int IRQ_OVR      = 1;  // Overrun event
   localparam int IRQ_FRM      = 2;  // Framing error event

   // ---------------------------------------------------------------
   // Writable masks and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] BC_WR_MASK  = 8'h1b;
   localparam logic [7:0] RS_WR_MASK  = 8'hf8;
   localparam logic [7:0] TS_WR_MASK  = 8'hfd;
   localparam logic [7:0] BC_RESET    = 8'h00; // 8-bit divisor after reset
   localparam logic [7:0] RS_RESET    = 8'h00;
   localparam logic [7:0] TS_RESET    = 8'h00;
   localparam logic [7:0] DIV_RESET   = 8'h00;
   localparam logic [2:0] IRQ_RESET   = 3'h0;

   // ---------------------------------------------------------------
   // Baud timing
   // ---------------------------------------------------------------
   localparam logic [1:0] PRE_SLOW    = 2'h3; // Extra divide by 4
   localparam logic [1:0] PRE_NONE    = 2'h0;
   localparam logic [3:0] OS_FULL     = 4'hf; // 16 samples per bit, last
   localparam logic [3:0] OS_QUART    = 4'h3; // 4 samples per bit, last
   localparam logic [3:0] BITS_EIGHT  = 4'h7; // Last data bit index
   localparam logic [3:0] BITS_NINE   = 4'h8;

   // Receiver states
   typedef enum logic [1:0] {
      RX_IDLE, RX_START, RX_DATA, RX_STOP
   } ubr_rx_state_type;

endpackage : ubr_pkg

// ### hw/ubr_receiver.sv
// Purpose: Asynchronous serial receiver with address detect and baud timer.
// Assumes: Classic Wishbone slave; receive line synchronous to CLK_I.
// Notes:   Two-entry receive buffer; ack one cycle after request seen.
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module ubr_receiver
   import ubr_pkg::*;
(
   // Clock, reset and enable
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        CE_I,
   // Wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   // Serial line and events
   input  wire logic        RX_I,
   output logic             BAUD_TICK_O,
   output logic             INT_O
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0]        bc_r, rs_r, ts_r, div_lo_r, div_hi_r;
   logic              ovr_r, ovr_nxt;
   logic [2:0]        irq_stat_r, irq_stat_nxt, irq_en_r;
   logic              ack_r, int_r, tick_out_r;
   logic [31:0]       dat_r;
   logic [15:0]       tmr_r, tmr_nxt;
   logic [1:0]        pre_r, pre_nxt;
   ubr_rx_state_type  st_r, st_nxt;
   logic [3:0]        smp_r, smp_nxt;
   logic [3:0]        bit_r, bit_nxt;
   logic [8:0]        sh_r, sh_nxt;
   logic              rx_r;
   logic [9:0]        buf_r [2];
   logic              wp_r, rp_r;
   logic [1:0]        cnt_r, cnt_nxt;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire        req      = CYC_I & STB_I;
   wire        acc      = req & ack_r;            // Takes effect at ack edge
   wire        wr_lane  = acc & WE_I & SEL_I[0];
   wire        rd_acc   = acc & ~WE_I;
   wire [7:0]  wd       = DAT_I[7:0];
   wire        wr_bc    = wr_lane & (ADR_I == OFF_BAUD_CTL);
   wire        wr_rs    = wr_lane & (ADR_I == OFF_RX_STAT);
   wire        wr_lo    = wr_lane & (ADR_I == OFF_DIV_LOW);
   wire        wr_hi    = wr_lane & (ADR_I == OFF_DIV_HIGH);
   wire        wr_ts    = wr_lane & (ADR_I == OFF_TX_STAT);
   wire        wr_clr   = wr_lane & (ADR_I == OFF_IRQ_CLR);
   wire        wr_en    = wr_lane & (ADR_I == OFF_IRQ_EN);
   wire        rd_data  = rd_acc & (ADR_I == OFF_RX_DATA);

   // Masked field update for partly read-only registers
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] val,
                                        input logic [7:0] mask);
      merge = (old & ~mask) | (val & mask);
   endfunction : merge

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   wire        wide     = bc_r[BC_WIDE];
   wire        sync_md  = ts_r[TS_SYNC];
   wire        fast     = ts_r[TS_HIGH] & ~sync_md;
   wire        port_on  = rs_r[RS_PORT_EN];
   wire        cont_on  = rs_r[RS_CONT_EN];
   wire        nine     = rs_r[RS_NINE];
   wire        addr_det = rs_r[RS_ADDR_DET] & nine;
   // Receiver runs only as an enabled asynchronous port
   wire        rx_en    = port_on & ~sync_md & cont_on;
   wire        rx_go    = rx_en & ~ovr_r;

   // Divisor: low byte only until wide mode is selected
   wire [15:0] div_n    = wide ? {div_hi_r, div_lo_r}
                               : {8'h00, div_lo_r};

   // Multiplier 64/16/16/4 async, 4 sync, split into a prescale
   // and oversampling count; slow 8-bit async needs the extra /4.
   wire        slow     = ~wide & ~fast & ~sync_md;
   wire        quart    = sync_md | (wide & fast);
   wire [1:0]  pre_max  = slow ? PRE_SLOW : PRE_NONE;
   wire [3:0]  os_max   = quart ? OS_QUART : OS_FULL;
   wire [3:0]  os_half  = {1'b0, os_max[3:1]};

   // ---------------------------------------------------------------
   // Free-running baud timer
   // ---------------------------------------------------------------
   wire        tmr_wrap = (tmr_r == div_n);
   wire        tick     = tmr_wrap & (pre_r == pre_max);

   // Divisor writes restart the period at once, not after a wrap
   always_comb begin
      tmr_nxt = tmr_wrap ? 16'h0000 : tmr_r + 16'h0001;
      pre_nxt = tmr_wrap ? ((pre_r == pre_max) ? 2'h0 : pre_r + 2'h1)
                         : pre_r;
      if (wr_lo | wr_hi) begin
         tmr_nxt = 16'h0000;
         pre_nxt = 2'h0;
      end
   end

   // ---------------------------------------------------------------
   // Receiver frame sequencer
   // ---------------------------------------------------------------
   wire [3:0]  last_bit = nine ? BITS_NINE : BITS_EIGHT;
   wire        smp_end  = (smp_r == os_max);
   wire        stop_now = (st_r == RX_STOP) & tick & smp_end;
   // Eight-bit frames finish with data in the upper eight bits
   wire [8:0]  frame    = nine ? sh_r : {1'b0, sh_r[8:1]};
   wire        frame_er = ~rx_r;
   // Address detect drops characters whose ninth bit is zero
   wire        keep     = ~addr_det | frame[8];
   wire        full     = (cnt_r == 2'h2);
   wire        push     = stop_now & keep & ~full;
   wire        ovr_ev   = stop_now & keep & full;
   wire        frm_ev   = push & frame_er;
   wire        pop      = rd_data & (cnt_r != 2'h0);

   // Next state; mid-bit sampling via oversample counter
   always_comb begin
      st_nxt  = st_r;
      smp_nxt = smp_r;
      bit_nxt = bit_r;
      sh_nxt  = sh_r;
      case (st_r)
         RX_IDLE: begin
            smp_nxt = 4'h0;
            bit_nxt = 4'h0;
            if (rx_go & ~rx_r) begin
               st_nxt = RX_START;
            end
         end
         RX_START: begin
            if (tick) begin
               smp_nxt = smp_r + 4'h1;
               if (smp_r == os_half) begin
                  smp_nxt = 4'h0;
                  // A high line at mid start bit was a glitch
                  st_nxt  = rx_r ? RX_IDLE : RX_DATA;
               end
            end
         end
         RX_DATA: begin
            if (tick) begin
               smp_nxt = smp_r + 4'h1;
               if (smp_end) begin
                  smp_nxt = 4'h0;
                  sh_nxt  = {rx_r, sh_r[8:1]};           // LSB first
                  bit_nxt = bit_r + 4'h1;
                  if (bit_r == last_bit) begin
                     st_nxt = RX_STOP;
                  end
               end
            end
         end
         RX_STOP: begin
            if (tick) begin
               smp_nxt = smp_r + 4'h1;
               if (smp_end) begin
                  st_nxt = RX_IDLE;
               end
            end
         end
         default: begin
            st_nxt = RX_IDLE;
         end
      endcase
      // Disabling reception abandons a partial character
      if (!rx_go) begin
         st_nxt = RX_IDLE;
      end
   end

   // ---------------------------------------------------------------
   // Buffer count and error / event flags
   // ---------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      if (push & ~pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop & ~push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   // Overrun holds until receive enable drops; a new overrun wins
   wire cont_clr = wr_rs & ~wd[RS_CONT_EN];
   assign ovr_nxt = ovr_ev | (ovr_r & ~cont_clr);

   // Sticky events; a set in the clearing cycle survives
   wire [2:0] irq_set = {frm_ev, ovr_ev, push};
   wire [2:0] irq_clr = wr_clr ? wd[2:0] : 3'h0;
   assign irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);

   // ---------------------------------------------------------------
   // Read data selection
   // ---------------------------------------------------------------
   wire [9:0] head     = buf_r[rp_r];
   wire       idle_bit = (st_r == RX_IDLE);
   wire [7:0] bc_rd    = {1'b0, idle_bit, bc_r[5:0]};
   // Error and ninth bit follow the oldest buffered character
   wire [7:0] rs_rd    = {rs_r[7:3], head[9], ovr_r, head[8]};
   wire [7:0] ts_rd    = {ts_r[7:2], 1'b1, ts_r[0]};     // No transmitter
   wire [7:0] rd_byte  =
      (ADR_I == OFF_BAUD_CTL) ? bc_rd :
      (ADR_I == OFF_RX_STAT)  ? rs_rd :
      (ADR_I == OFF_DIV_LOW)  ? div_lo_r :
      (ADR_I == OFF_DIV_HIGH) ? div_hi_r :
      (ADR_I == OFF_TX_STAT)  ? ts_rd :
      (ADR_I == OFF_RX_DATA)  ? head[7:0] :
      (ADR_I == OFF_IRQ_STAT) ? {5'h00, irq_stat_r} :
      (ADR_I == OFF_IRQ_EN)   ? {5'h00, irq_en_r} :
                                8'h00;                   // Unmapped: zero

   // ---------------------------------------------------------------
   // Bus handshake and read data
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else if (CE_I) begin
         ack_r <= req & ~ack_r;
         dat_r <= {24'h00_0000, rd_byte};
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         bc_r     <= BC_RESET;
         rs_r     <= RS_RESET;
         ts_r     <= TS_RESET;
         div_lo_r <= DIV_RESET;
         div_hi_r <= DIV_RESET;
         irq_en_r <= IRQ_RESET;
      end else if (CE_I) begin
         if (wr_bc) bc_r <= merge(bc_r, wd, BC_WR_MASK);
         if (wr_rs) rs_r <= merge(rs_r, wd, RS_WR_MASK);
         if (wr_ts) ts_r <= merge(ts_r, wd, TS_WR_MASK);
         if (wr_lo) div_lo_r <= wd;
         if (wr_hi) div_hi_r <= wd;
         if (wr_en) irq_en_r <= wd[2:0];
      end
   end

   // ---------------------------------------------------------------
   // Flags and interrupt output
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         ovr_r      <= 1'b0;
         irq_stat_r <= IRQ_RESET;
         int_r      <= 1'b0;
      end else if (CE_I) begin
         ovr_r      <= ovr_nxt;
         irq_stat_r <= irq_stat_nxt;
         int_r      <= |(irq_stat_nxt & irq_en_r);
      end
   end

   // ---------------------------------------------------------------
   // Baud timer registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         tmr_r      <= 16'h0000;
         pre_r      <= 2'h0;
         tick_out_r <= 1'b0;
      end else if (CE_I) begin
         tmr_r      <= tmr_nxt;
         pre_r      <= pre_nxt;
         tick_out_r <= tick & ~(wr_lo | wr_hi);
      end
   end

   // ---------------------------------------------------------------
   // Receiver registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         st_r  <= RX_IDLE;
         smp_r <= 4'h0;
         bit_r <= 4'h0;
         sh_r  <= 9'h000;
         rx_r  <= 1'b1;                                  // Line idles high
      end else if (CE_I) begin
         st_r  <= st_nxt;
         smp_r <= smp_nxt;
         bit_r <= bit_nxt;
         sh_r  <= sh_nxt;
         rx_r  <= RX_I;
      end
   end

   // ---------------------------------------------------------------
   // Two-entry receive buffer, oldest first
   // ---------------------------------------------------------------
   // Two entries give software two character times to service a flag
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         buf_r[0] <= 10'h000;
         buf_r[1] <= 10'h000;
         wp_r     <= 1'b0;
         rp_r     <= 1'b0;
         cnt_r    <= 2'h0;
      end else if (CE_I) begin
         if (push) begin
            buf_r[wp_r] <= {frame_er, frame};
            wp_r        <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign DAT_O       = dat_r;
   assign ACK_O       = ack_r;
   assign INT_O       = int_r;
   assign BAUD_TICK_O = tick_out_r;

endmodule : ubr_receiver

// ### verif/ubr_line_tx.sv
// Purpose: Serial line driver standing in for a remote transmitter.
// Assumes: Bit period is given in bench clocks; the line idles high.
// Notes:   A low stop bit is sent only where a framing fault is wanted.
`timescale 1ns/1ps
module ubr_line_tx (
   // Clock and serial line
   input  wire logic clk_i,
   output logic      rx_o
);
   // Line rests high between frames
   initial rx_o = 1'b1;

   // -------------------------------------------------------------
   // One frame: low start, data LSB first, stop
   // -------------------------------------------------------------
   task automatic send(input logic [8:0] d, input int nb, input int per,
                       input logic stp);
      for (int i = 0; i < nb + 2; i++) begin
         @(posedge clk_i);
         rx_o <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stp;
         repeat (per - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      rx_o <= 1'b1; // Back to idle so no false start follows
   endtask : send
endmodule : ubr_line_tx

// ### verif/ubr_receiver_assertions.sv
// Purpose: Concurrent checks on the receiver's bus and event ports.
// Assumes: Bound to ubr_receiver; sees only its ports.
// Notes:   Checks are off while reset is high; CE_I stays high.
`timescale 1ns/1ps
module ubr_receiver_assertions
   import ubr_pkg::*;
(
   // Clock, reset and enable
   input wire logic        CLK_I,
   input wire logic        SYS_RST_I,
   input wire logic        CE_I,
   // Bus
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic        WE_I,
   input wire logic [7:0]  ADR_I,
   input wire logic [3:0]  SEL_I,
   input wire logic [31:0] DAT_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   // Line and events
   input wire logic        RX_I,
   input wire logic        BAUD_TICK_O,
   input wire logic        INT_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);

   // Bus answer timing and read data shape
   a_ack_latency: assert property (CYC_I && STB_I && !ACK_O && CE_I
      |=> ACK_O) else $error("ack missing after request");
   a_ack_single: assert property (ACK_O |=> !ACK_O)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
      else $error("ack without request");
   a_data_upper: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (ACK_O && !WE_I && ADR_I > OFF_IRQ_EN
      |-> DAT_O == 32'h0) else $error("unmapped read not zero");
   a_tx_empty: assert property (ACK_O && !WE_I && ADR_I == OFF_TX_STAT
      |-> DAT_O[TS_EMPTY]) else $error("transmit empty bit low");
   a_irq_spare: assert property (
      ACK_O && !WE_I && ADR_I == OFF_IRQ_STAT |-> DAT_O[7:3] == 5'h0)
      else $error("spare event bits set");
   a_quiet_rst: assert property (
      $fell(SYS_RST_I) |-> !INT_O && !BAUD_TICK_O && !ACK_O)
      else $error("outputs active after reset");

   // Main traffic seen
   c_write: cover property (ACK_O && WE_I);
   c_data: cover property (ACK_O && !WE_I && ADR_I == OFF_RX_DATA);
   c_int: cover property ($rose(INT_O));
endmodule : ubr_receiver_assertions

// ### verif/ubr_receiver_tb.sv
// Purpose: Register level bench for the serial receiver.
// Assumes: Remote transmitter model on RX_I; CE_I and SEL_I held.
// Notes:   Rates kept short so every mode fits one short run.
`timescale 1ns/1ps
module ubr_receiver_tb
   import ubr_pkg::*;
;
   logic        CLK_I = 1'b0, SYS_RST_I = 1'b1;
   logic        CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
   logic [7:0]  ADR_I = 8'h00;
   logic [31:0] DAT_I = 32'h0;
   wire  [31:0] DAT_O;
   wire         ACK_O, RX_I, BAUD_TICK_O, INT_O;
   int          mismatches = 0, check_count = 0;
   localparam logic [7:0] RO [8] = '{OFF_BAUD_CTL, OFF_RX_STAT,
      OFF_DIV_LOW, OFF_DIV_HIGH, OFF_TX_STAT, OFF_IRQ_STAT, OFF_IRQ_EN, 8'h30};
   localparam logic [7:0] RV [8] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h02,
      8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WO [8] = '{OFF_BAUD_CTL, OFF_DIV_LOW,
      OFF_DIV_HIGH, OFF_TX_STAT, OFF_RX_STAT, OFF_IRQ_STAT, OFF_IRQ_EN, 8'h30};
   localparam logic [7:0] WV [8] = '{8'h5b, 8'hff, 8'hff, 8'hff, 8'hf8,
      8'h00, 8'h07, 8'h00};
   // Rate table: control, speed, divisor low, high, clocks per bit
   localparam logic [7:0] MB [5] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h08};
   localparam logic [7:0] MT [5] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h04};
   localparam logic [7:0] ML [5] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h00};
   localparam logic [7:0] MH [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
   localparam int         MP [5] = '{64, 32, 32, 12, 1028};
   localparam logic [7:0] NT [3] = '{8'h04, 8'h14, 8'h04};
   localparam logic [7:0] NR [3] = '{8'h80, 8'h90, 8'h10};

   // Clock and parts
   initial forever #50 CLK_I = ~CLK_I;
   ubr_receiver i_dut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(1'b1),
      .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
      .SEL_I(4'h1), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
      .RX_I(RX_I), .BAUD_TICK_O(BAUD_TICK_O), .INT_O(INT_O));
   ubr_line_tx i_tx (.clk_i(CLK_I), .rx_o(RX_I));

   // -------------------------------------------------------------
   // Bus cycles and comparisons
   // -------------------------------------------------------------
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      @(posedge CLK_I);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I  <= we;
      ADR_I <= a;
      DAT_I <= {24'h0, d};
      do begin
         @(posedge CLK_I);
      end while (ACK_O !== 1'b1); // Watchdog ends a lost answer
      q = DAT_O[7:0];
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
   endtask : wb
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), e, q);
   endtask : rdc
   // Interrupt output lags its cause by a cycle
   task automatic intc(input logic e);
      repeat (2) @(posedge CLK_I);
      chk("INT_O", {7'h0, e}, {7'h0, INT_O});
   endtask : intc
   // Baud tick spacing; the first tick lags the divisor write by one
   task automatic tickc(input int e);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge CLK_I);
            n++;
         end while (BAUD_TICK_O !== 1'b1);
         chk("BAUD_TICK_O low", 8'(e + 1 - k), 8'(n));
         chk("BAUD_TICK_O high", 8'((e + 1 - k) >> 8), 8'(n >> 8));
      end
   endtask : tickc
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // Watchdog sized well above the slowest rate's frames
   initial begin
      repeat (40000) @(posedge CLK_I);
      mismatches++;
      wrap_up();
   end

   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial begin
      repeat (16) @(posedge CLK_I);
      SYS_RST_I <= 1'b0;
      foreach (RO[i]) rdc(RO[i], RV[i]);
      $display("Test reset done");
      foreach (WO[i]) begin
         wr(WO[i], 8'hff);
         rdc(WO[i], WV[i]);
      end
      $display("Test access done");
      wr(OFF_IRQ_EN, 8'h01);
      for (int i = 0; i < 5; i++) begin
         wr(OFF_RX_STAT, 8'h00);
         wr(OFF_BAUD_CTL, MB[i]);
         wr(OFF_TX_STAT, MT[i]);
         wr(OFF_DIV_LOW, ML[i]);
         wr(OFF_DIV_HIGH, MH[i]);
         tickc(MP[i] / ((i < 3) ? 16 : 4));
         wr(OFF_RX_STAT, 8'h90);
         fork
            i_tx.send({1'b0, 8'h5a ^ 8'(i)}, 8, MP[i], 1'b1);
            begin
               repeat (MP[i] * 3) @(posedge CLK_I);
               rdc(OFF_BAUD_CTL, MB[i]);
            end
         join
         rdc(OFF_BAUD_CTL, MB[i] | 8'h40);
         rdc(OFF_IRQ_STAT, 8'h01);
         intc(1'b1);
         rdc(OFF_RX_DATA, 8'h5a ^ 8'(i));
         wr(OFF_IRQ_CLR, 8'h07);
         intc(1'b0);
      end
      $display("Test rates done");
      wr(OFF_DIV_LOW, 8'h01);
      wr(OFF_DIV_HIGH, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(OFF_TX_STAT, NT[i]);
         wr(OFF_RX_STAT, NR[i]);
         i_tx.send(9'h0f0, 8, 8, 1'b1);
         rdc(OFF_IRQ_STAT, 8'h00);
      end
      $display("Test gating done");
      wr(OFF_BAUD_CTL, 8'h00);
      wr(OFF_TX_STAT, 8'h10);
      wr(OFF_DIV_LOW, 8'h01);
      tickc(2);
      wr(OFF_BAUD_CTL, 8'h08);
      $display("Test sync rate done");
      wr(OFF_TX_STAT, 8'h04);
      wr(OFF_RX_STAT, 8'h90);
      i_tx.send(9'h011, 8, 8, 1'b1);
      i_tx.send(9'h022, 8, 8, 1'b1);
      i_tx.send(9'h033, 8, 8, 1'b1);
      rdc(OFF_RX_STAT, 8'h92);
      rdc(OFF_IRQ_STAT, 8'h03);
      rdc(OFF_RX_DATA, 8'h11);
      rdc(OFF_RX_DATA, 8'h22);
      wr(OFF_IRQ_CLR, 8'h01);
      intc(1'b0);
      wr(OFF_IRQ_EN, 8'h03);
      intc(1'b1);
      wr(OFF_RX_STAT, 8'h80);
      rdc(OFF_RX_STAT, 8'h80);
      wr(OFF_IRQ_CLR, 8'h07);
      wr(OFF_IRQ_EN, 8'h01);
      $display("Test overrun done");
      wr(OFF_RX_STAT, 8'hd8);
      i_tx.send(9'h055, 9, 8, 1'b1);
      rdc(OFF_IRQ_STAT, 8'h00);
      i_tx.send(9'h1a3, 9, 8, 1'b1);
      rdc(OFF_RX_STAT, 8'hd9);
      rdc(OFF_RX_DATA, 8'ha3);
      wr(OFF_IRQ_CLR, 8'h07);
      wr(OFF_RX_STAT, 8'hd0);
      i_tx.send(9'h03c, 9, 8, 1'b1);
      rdc(OFF_IRQ_STAT, 8'h01);
      rdc(OFF_RX_STAT, 8'hd0);
      rdc(OFF_RX_DATA, 8'h3c);
      wr(OFF_IRQ_CLR, 8'h07);
      i_tx.send(9'h011, 9, 8, 1'b0);
      rdc(OFF_RX_STAT, 8'hd4);
      rdc(OFF_IRQ_STAT, 8'h05);
      rdc(OFF_RX_DATA, 8'h11);
      wr(OFF_RX_STAT, 8'h00);
      $display("Test address done");
      wrap_up();
   end
endmodule : ubr_receiver_tb

bind ubr_receiver ubr_receiver_assertions i_chk (.CLK_I(CLK_I),
   .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I),
   .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
   .ACK_O(ACK_O), .RX_I(RX_I), .BAUD_TICK_O(BAUD_TICK_O), .INT_O(INT_O));
